/* File: hw/accumulator_instruction_decoder.sv */
// Purpose: Decoder and sequencer of a 16-bit accumulator minicomputer.
// Assumes: One 10 MHz clock; memory and registers reached over Wishbone.
// Notes: Skip-on-bit number 0 is the accumulator's most significant bit.
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "acc_core_cfg.svh"

module accumulator_instruction_decoder (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [`ACC_WORD_W-1:0] io_in_data_i,
    input wire logic [`ACC_SENSE_N-1:0] sense_i,
    output acc_core_pkg::io_bus_t io_o
);

    localparam int WW = `ACC_WORD_W;
    localparam int AW = `ACC_ADDR_W;

    acc_core_pkg::core_state_t s;
    acc_core_pkg::core_state_t nxt;
    logic [WW-1:0] mem [0:`ACC_MEM_DEPTH-1];
    logic [AW-1:0] rd_addr;
    logic [WW-1:0] rd_word;
    logic [WW-1:0] bus_word;
    logic mem_we;
    logic [AW-1:0] mem_wa;
    logic [WW-1:0] mem_wd;

    // Byte-lane merge shared by the PC, ACC, MADDR and MDATA registers.
    function automatic logic [WW-1:0] lane_merge(
        input logic [WW-1:0] old,
        input logic [31:0] wd,
        input logic [3:0] sel
    );
        logic [WW-1:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = wd[7:0];
        end
        if (sel[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : lane_merge

    function automatic logic is_zero(input logic [WW-1:0] w);
        return w == '0;
    endfunction : is_zero

    assign rd_word = mem[rd_addr];
    assign bus_word = mem[s.maddr];

    always_comb begin
        logic [WW-1:0] merged;
        logic [WW-1:0] sum;
        logic [WW-1:0] inc;
        logic [3:0] n;
        logic [5:0] reg_idx;
        acc_core_pkg::opcode_t op;
        acc_core_pkg::subop_t sub;
        merged = '0;
        sum = '0;
        inc = '0;
        n = s.ir[`ACC_F_N_HI:`ACC_F_N_LO];
        reg_idx = wb_adr_i[7:2];
        op = acc_core_pkg::opcode_t'(s.ir[`ACC_F_OP_HI:`ACC_F_OP_LO]);
        sub = acc_core_pkg::subop_t'(s.ir[`ACC_F_SUB_HI:`ACC_F_SUB_LO]);
        nxt = s;
        mem_we = 1'b0;
        mem_wa = s.maddr;
        mem_wd = '0;
        rd_addr = s.ea;
        nxt.ack = 1'b0;
        nxt.io.output_strobe = 1'b0;

        // External levels pass two flip-flops before any use.
        nxt.sense_s1 = sense_i;
        nxt.sense_s2 = s.sense_s1;
        nxt.din_s1 = io_in_data_i;
        nxt.din_s2 = s.din_s1;

        // Wishbone slave: one wait state, ack for one cycle.
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            nxt.ack = 1'b1;
            nxt.rdata = '0;
            if (wb_we_i) begin
                unique case (reg_idx)
                    `ACC_OFS_CTRL: begin
                        if (wb_sel_i[0]) begin
                            nxt.run = wb_dat_i[`ACC_CTRL_RUN];
                            nxt.step = wb_dat_i[`ACC_CTRL_STEP];
                        end
                    end
                    `ACC_OFS_STATUS: begin
                        if (wb_sel_i[0] && wb_dat_i[`ACC_ST_ILLEGAL]) begin
                            nxt.illegal = 1'b0;
                        end
                    end
                    `ACC_OFS_PC: begin
                        merged = lane_merge({4'h0, s.program_counter},
                            wb_dat_i, wb_sel_i);
                        nxt.program_counter = merged[AW-1:0];
                    end
                    `ACC_OFS_ACC: begin
                        nxt.acc = lane_merge(s.acc, wb_dat_i, wb_sel_i);
                    end
                    `ACC_OFS_MADDR: begin
                        merged = lane_merge({4'h0, s.maddr}, wb_dat_i,
                            wb_sel_i);
                        nxt.maddr = merged[AW-1:0];
                    end
                    `ACC_OFS_MDATA: begin
                        mem_we = 1'b1;
                        mem_wd = lane_merge(bus_word, wb_dat_i, wb_sel_i);
                        nxt.maddr = s.maddr + 1'b1;
                    end
                    default: begin
                    end
                endcase
            end else begin
                unique case (reg_idx)
                    `ACC_OFS_CTRL: begin
                        nxt.rdata[`ACC_CTRL_RUN] = s.run;
                        nxt.rdata[`ACC_CTRL_STEP] = s.step;
                    end
                    `ACC_OFS_STATUS: begin
                        nxt.rdata[`ACC_ST_RUNNING] =
                            (s.st != acc_core_pkg::ST_IDLE);
                        nxt.rdata[`ACC_ST_OVF] = s.ovf;
                        nxt.rdata[`ACC_ST_ILLEGAL] = s.illegal;
                        nxt.rdata[`ACC_ST_IOWAIT] = s.io.input_strobe;
                    end
                    `ACC_OFS_PC: nxt.rdata[AW-1:0] = s.program_counter;
                    `ACC_OFS_ACC: nxt.rdata[WW-1:0] = s.acc;
                    `ACC_OFS_MADDR: nxt.rdata[AW-1:0] = s.maddr;
                    `ACC_OFS_MDATA: begin
                        nxt.rdata[WW-1:0] = bus_word;
                        nxt.maddr = s.maddr + 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Core sequencer; its writes override a bus write in the same cycle.
        unique case (s.st)
            acc_core_pkg::ST_IDLE: begin
                if (s.run || s.step) begin
                    nxt.step = 1'b0;
                    nxt.st = acc_core_pkg::ST_FETCH;
                end
            end
            acc_core_pkg::ST_FETCH: begin
                rd_addr = s.program_counter;
                nxt.ir = rd_word;
                nxt.program_counter = s.program_counter + 1'b1;
                nxt.st = acc_core_pkg::ST_DECODE;
            end
            acc_core_pkg::ST_DECODE: begin
                nxt.ea = s.ir[`ACC_F_ADR_HI:0];
                if (s.ir[`ACC_F_IND] && op != acc_core_pkg::OP_OPER) begin
                    nxt.st = acc_core_pkg::ST_INDIR;
                end else begin
                    nxt.st = acc_core_pkg::ST_EXEC;
                end
            end
            acc_core_pkg::ST_INDIR: begin
                // pointer word, flag and address.
                // The fifteen-bit address is cut to the 4K space.
                nxt.ea = rd_word[AW-1:0];
                if (!rd_word[`ACC_F_IND]) begin
                    nxt.st = acc_core_pkg::ST_EXEC;
                end
            end
            acc_core_pkg::ST_EXEC: begin
                nxt.st = s.run ? acc_core_pkg::ST_FETCH
                    : acc_core_pkg::ST_IDLE;
                unique case (op)
                    acc_core_pkg::OP_LOAD: nxt.acc = rd_word;
                    acc_core_pkg::OP_JUMP: nxt.program_counter = s.ea;
                    acc_core_pkg::OP_ADD: begin
                        sum = s.acc + rd_word;
                        nxt.acc = sum;
                        nxt.ovf = (s.acc[WW-1] == rd_word[WW-1]) &&
                            (sum[WW-1] != s.acc[WW-1]);
                    end
                    acc_core_pkg::OP_JSR: begin
                        mem_we = 1'b1;
                        mem_wa = s.ea;
                        mem_wd = {4'h0, s.program_counter};
                        nxt.program_counter = s.ea + 1'b1;
                        nxt.acc = '0;
                    end
                    acc_core_pkg::OP_AND: nxt.acc = s.acc & rd_word;
                    acc_core_pkg::OP_STORE: begin
                        mem_we = 1'b1;
                        mem_wa = s.ea;
                        mem_wd = s.acc;
                    end
                    acc_core_pkg::OP_IAS: begin
                        inc = rd_word + 1'b1;
                        mem_we = 1'b1;
                        mem_wa = s.ea;
                        mem_wd = inc;
                        nxt.acc = inc;
                        nxt.ovf = (rd_word == `ACC_MAX_POS);
                        if (is_zero(inc)) begin
                            nxt.program_counter = s.program_counter + 1'b1;
                        end
                    end
                    acc_core_pkg::OP_OPER: begin
                        unique case (sub)
                            acc_core_pkg::SUB_SHIFT_LEFT:
                                nxt.acc = s.acc << n;
                            acc_core_pkg::SUB_ROTATE_LEFT:
                                nxt.acc = (s.acc << n) |
                                    (s.acc >> (5'd16 - {1'b0, n}));
                            acc_core_pkg::SUB_SKIP_ZERO: begin
                                if (is_zero(s.acc)) begin
                                    nxt.program_counter =
                                        s.program_counter + 1'b1;
                                end
                            end
                            acc_core_pkg::SUB_SKIP_NONZERO: begin
                                if (!is_zero(s.acc)) begin
                                    nxt.program_counter =
                                        s.program_counter + 1'b1;
                                end
                            end
                            acc_core_pkg::SUB_SKIP_BIT_SET: begin
                                if (s.acc[4'hf - n]) begin
                                    nxt.program_counter =
                                        s.program_counter + 1'b1;
                                end
                            end
                            acc_core_pkg::SUB_SKIP_BIT_CLEAR: begin
                                if (!s.acc[4'hf - n]) begin
                                    nxt.program_counter =
                                        s.program_counter + 1'b1;
                                end
                            end
                            acc_core_pkg::SUB_SKIP_NO_OVF: begin
                                if (!s.ovf) begin
                                    nxt.program_counter =
                                        s.program_counter + 1'b1;
                                end
                            end
                            acc_core_pkg::SUB_NEGATE:
                                nxt.acc = (~s.acc) + 1'b1;
                            acc_core_pkg::SUB_WORD_OUTPUT: begin
                                nxt.io.data = s.acc;
                                nxt.io.dev = n;
                                nxt.io.func =
                                    s.ir[`ACC_F_FN_HI:`ACC_F_FN_LO];
                                nxt.io.output_strobe = 1'b1;
                            end
                            acc_core_pkg::SUB_WORD_INPUT: begin
                                nxt.io.dev = n;
                                nxt.io.func =
                                    s.ir[`ACC_F_FN_HI:`ACC_F_FN_LO];
                                nxt.io.input_strobe = 1'b1;
                                nxt.hold = `ACC_IN_HOLD;
                                nxt.st = acc_core_pkg::ST_IN_WAIT;
                            end
                            acc_core_pkg::SUB_TEST_READY: begin
                                if (s.sense_s2[n]) begin
                                    nxt.program_counter =
                                        s.program_counter + 1'b1;
                                end
                            end
                            acc_core_pkg::SUB_CLEAR: begin
                                nxt.acc = '0;
                                nxt.ovf = 1'b0;
                            end
                            default: begin
                                // Unknown codes stop the core for software.
                                nxt.illegal = 1'b1;
                                nxt.run = 1'b0;
                                nxt.st = acc_core_pkg::ST_IDLE;
                            end
                        endcase
                    end
                endcase
            end
            acc_core_pkg::ST_IN_WAIT: begin
                // The hold covers the two-stage input synchroniser delay.
                if (s.hold == 3'h0) begin
                    nxt.acc = s.din_s2;
                    nxt.io.input_strobe = 1'b0;
                    nxt.st = s.run ? acc_core_pkg::ST_FETCH
                        : acc_core_pkg::ST_IDLE;
                end else begin
                    nxt.hold = s.hold - 1'b1;
                end
            end
            default: nxt.st = acc_core_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.program_counter <= `ACC_RST_PC;
            s.acc <= `ACC_RST_ACC;
        end else begin
            s <= nxt;
        end
    end

    // Memory has no reset; software loads it through the data window.
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdata;
    assign io_o = s.io;

endmodule : accumulator_instruction_decoder
`default_nettype wire

/* File: hw/acc_core_cfg.svh */
// Purpose: Offsets, field positions, reset values and counts of the core.
// Assumes: Included by the package and the core module only.
// Notes: Definitions only.
`ifndef ACC_CORE_CFG_SVH
`define ACC_CORE_CFG_SVH

`define ACC_WORD_W 16
`define ACC_ADDR_W 12
`define ACC_MEM_DEPTH 4096
`define ACC_DEV_W 4
`define ACC_SENSE_N 16

`define ACC_F_IND 15
`define ACC_F_OP_HI 14
`define ACC_F_OP_LO 12
`define ACC_F_ADR_HI 11
`define ACC_F_SUB_HI 11
`define ACC_F_SUB_LO 8
`define ACC_F_N_HI 7
`define ACC_F_N_LO 4
`define ACC_F_FN_HI 3
`define ACC_F_FN_LO 0

`define ACC_OFS_CTRL 6'h00
`define ACC_OFS_STATUS 6'h01
`define ACC_OFS_PC 6'h02
`define ACC_OFS_ACC 6'h03
`define ACC_OFS_MADDR 6'h04
`define ACC_OFS_MDATA 6'h05

`define ACC_CTRL_RUN 0
`define ACC_CTRL_STEP 1
`define ACC_ST_RUNNING 0
`define ACC_ST_OVF 1
`define ACC_ST_ILLEGAL 2
`define ACC_ST_IOWAIT 3

`define ACC_RST_PC 12'h000
`define ACC_RST_ACC 16'h0000
`define ACC_IN_HOLD 3'h4
`define ACC_MAX_POS 16'h7fff

`endif

/* File: hw/acc_core_pkg.sv */
// Purpose: Types shared by the accumulator core and its bench.
// Assumes: The cfg header supplies the word, address, device and sense widths.
// Notes: Enum order fixes the opcode and sub-operation codes.
`include "acc_core_cfg.svh"

package acc_core_pkg;

    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_DECODE, ST_INDIR, ST_EXEC, ST_IN_WAIT
    } state_t;

    typedef enum logic [2:0] {
        OP_LOAD, OP_JUMP, OP_ADD, OP_JSR, OP_AND, OP_STORE, OP_IAS, OP_OPER
    } opcode_t;

    typedef enum logic [3:0] {
        SUB_SHIFT_LEFT, SUB_ROTATE_LEFT, SUB_SKIP_ZERO, SUB_SKIP_NONZERO,
        SUB_SKIP_BIT_SET, SUB_SKIP_BIT_CLEAR, SUB_SKIP_NO_OVF, SUB_NEGATE,
        SUB_WORD_OUTPUT, SUB_WORD_INPUT, SUB_TEST_READY, SUB_CLEAR
    } subop_t;

    typedef struct packed {
        logic [`ACC_WORD_W-1:0] data;
        logic [`ACC_DEV_W-1:0] dev;
        logic [`ACC_DEV_W-1:0] func;
        logic output_strobe;
        logic input_strobe;
    } io_bus_t;

    typedef struct packed {
        state_t st;
        logic run;
        logic step;
        logic [`ACC_ADDR_W-1:0] program_counter;
        logic [`ACC_WORD_W-1:0] acc;
        logic [`ACC_WORD_W-1:0] ir;
        logic [`ACC_ADDR_W-1:0] ea;
        logic ovf;
        logic illegal;
        logic [2:0] hold;
        logic ack;
        logic [31:0] rdata;
        logic [`ACC_ADDR_W-1:0] maddr;
        io_bus_t io;
        logic [`ACC_SENSE_N-1:0] sense_s1;
        logic [`ACC_SENSE_N-1:0] sense_s2;
        logic [`ACC_WORD_W-1:0] din_s1;
        logic [`ACC_WORD_W-1:0] din_s2;
    } core_state_t;

endpackage : acc_core_pkg

/* File: verif/accumulator_instruction_decoder_properties.sv */
// Purpose: Port-level properties of the accumulator core.
// Assumes: Bound to the core and sees only its ports.
// Notes: Bus and strobe timing follow the agreed port contract.
`timescale 1ns/1ps
`default_nettype none
module accumulator_instruction_decoder_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [15:0] io_in_data_i,
    input wire logic [15:0] sense_i,
    input wire acc_core_pkg::io_bus_t io_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Acknowledge is a single pulse per access.
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answers: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_out_strobe_pulse: assert property (
        io_o.output_strobe |=> !io_o.output_strobe)
        else $error("output strobe longer than one cycle");
    // The strobe is seen high at five edges: four hold counts and the take.
    a_in_strobe_len: assert property (
        $rose(io_o.input_strobe)
        |-> io_o.input_strobe [*5] ##1 !io_o.input_strobe)
        else $error("input strobe not five cycles long");
    a_one_transfer: assert property (
        !(io_o.output_strobe && io_o.input_strobe))
        else $error("both strobes active together");
    a_sel_steady: assert property (
        io_o.input_strobe && $past(io_o.input_strobe)
        |-> $stable(io_o.dev) && $stable(io_o.func))
        else $error("device select moved during input");
    a_sel_cause: assert property (
        $changed(io_o.dev) || $changed(io_o.func)
        |-> io_o.output_strobe || $rose(io_o.input_strobe))
        else $error("device select changed without transfer");
    a_out_data_hold: assert property (
        $changed(io_o.data) |-> io_o.output_strobe)
        else $error("output data changed without strobe");
endmodule : accumulator_instruction_decoder_properties
bind accumulator_instruction_decoder
    accumulator_instruction_decoder_properties i_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .io_in_data_i(io_in_data_i), .sense_i(sense_i), .io_o(io_o));
`default_nettype wire

/* File: verif/io_device_model.sv */
// Purpose: Peripheral controllers on the parallel I/O bus.
// Assumes: One output device and one input device, fixed ready lines.
// Notes: Released input lines toggle so a stale word cannot pass.
`timescale 1ns/1ps
`default_nettype none
module io_device_model #(
    parameter logic [15:0] READY_MASK = 16'h0020,
    parameter logic [3:0] OUT_DEV = 4'h5,
    parameter logic [3:0] IN_DEV = 4'h6,
    parameter logic [15:0] IN_WORD = 16'ha5c3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire acc_core_pkg::io_bus_t io_i,
    output logic [15:0] sense_o,
    output logic [15:0] in_data_o,
    output logic [15:0] got_data_o,
    output logic [3:0] got_func_o,
    output logic [7:0] got_count_o
);
    logic [15:0] last;
    assign sense_o = READY_MASK;
    assign in_data_o = (io_i.input_strobe && io_i.dev == IN_DEV) ? IN_WORD
        : ~last;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last <= 16'h0000;
            got_data_o <= 16'h0000;
            got_func_o <= 4'h0;
            got_count_o <= 8'h00;
        end else begin
            last <= in_data_o;
            if (io_i.output_strobe && io_i.dev == OUT_DEV) begin
                got_data_o <= io_i.data;
                got_func_o <= io_i.func;
                got_count_o <= got_count_o + 8'h01;
            end
        end
    end
endmodule : io_device_model
`default_nettype wire

/* File: verif/accumulator_instruction_decoder_tb.sv */
// Purpose: Self-checking bench for the accumulator core.
// Assumes: Programs are loaded through the memory window registers.
// Notes: Each program ends on an illegal operate code, which halts the core.
`timescale 1ns/1ps
`default_nettype none
module accumulator_instruction_decoder_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0000_0000, rdat, wb_dat_o;
    logic wb_ack_o;
    logic [15:0] sense, din, got_data;
    logic [3:0] got_func;
    logic [7:0] got_count;
    acc_core_pkg::io_bus_t io;
    int num_errors = 0, total_checks = 0;
    accumulator_instruction_decoder i_accumulator_instruction_decoder (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .io_in_data_i(din),
        .sense_i(sense), .io_o(io));
    io_device_model i_io_device_model (.clk_i(clk_i), .rst_i(rst_i),
        .io_i(io), .sense_o(sense), .in_data_o(din), .got_data_o(got_data),
        .got_func_o(got_func), .got_count_o(got_count));
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    // Ack is sampled at each rising edge; read data is taken at the edge
    // where ack is seen high, and only then is the request released.
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic chk(input string what, input logic [31:0] exp, got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
        input string what);
        bus(1'b0, a, 32'h0000_0000);
        chk(what, exp, rdat);
    endtask : rd
    task automatic peek(input logic [11:0] a, input logic [15:0] exp);
        bus(1'b1, 8'h10, {20'h0_0000, a});
        rd(8'h14, {16'h0000, exp}, "memory word");
    endtask : peek
    task automatic load(input logic [11:0] a, input logic [15:0] w[$]);
        bus(1'b1, 8'h10, {20'h0_0000, a});
        foreach (w[i]) bus(1'b1, 8'h14, {16'h0000, w[i]});
    endtask : load
    task automatic go(input logic [11:0] pc, input logic [31:0] ctl);
        int n;
        n = 0;
        bus(1'b1, 8'h08, {20'h0_0000, pc});
        bus(1'b1, 8'h00, ctl);
        do begin
            bus(1'b0, 8'h04, 32'h0000_0000);
            n++;
        end while (rdat[0] !== 1'b0 && n < 100);
        if (n >= 100) num_errors++;
    endtask : go
    task automatic t_reset();
        rd(8'h08, 32'h0000_0000, "pc");
        rd(8'h0C, 32'h0000_0000, "acc");
        bus(1'b1, 8'h3C, 32'h0000_ffff);
        rd(8'h3C, 32'h0000_0000, "unmapped");
        $display("test reset done");
    endtask : t_reset
    task automatic t_move();
        load(12'h100, '{16'h1234, 16'h0f0f, 16'h7fff, 16'h0001});
        load(12'h000, '{16'h0100, 16'h4101, 16'h7040, 16'h7140, 16'h7700,
            16'h5104, 16'h7c00});
        go(12'h000, 32'h0000_0001);
        rd(8'h0C, 32'h0000_fbfe, "acc");
        peek(12'h104, 16'hfbfe);
        rd(8'h04, 32'h0000_0004, "status");
        $display("test move done");
    endtask : t_move
    task automatic t_skip();
        load(12'h010, '{16'h0102, 16'h2103, 16'h7600, 16'h5105, 16'h7b00,
            16'h7200, 16'h0100, 16'h7300, 16'h0101, 16'h7440, 16'h7b00,
            16'h7540, 16'h7600, 16'h7b00, 16'h7c00});
        go(12'h010, 32'h0000_0002);
        rd(8'h0C, 32'h0000_7fff, "step acc");
        rd(8'h08, 32'h0000_0011, "step pc");
        go(12'h011, 32'h0000_0001);
        peek(12'h105, 16'h8000);
        rd(8'h0C, 32'h0000_0f0f, "acc");
        rd(8'h04, 32'h0000_0004, "status");
        $display("test skip done");
    endtask : t_skip
    task automatic t_jump();
        load(12'h030, '{16'h8031, 16'h0040});
        load(12'h060, '{16'hffff, 16'h0005});
        load(12'h020, '{16'h9030, 16'h7c00});
        load(12'h040, '{16'h3050});
        load(12'h051, '{16'h6060, 16'h7c00, 16'h6061, 16'h7c00});
        go(12'h020, 32'h0000_0001);
        peek(12'h050, 16'h0041);
        peek(12'h060, 16'h0000);
        peek(12'h061, 16'h0006);
        rd(8'h0C, 32'h0000_0006, "acc");
        $display("test jump done");
    endtask : t_jump
    task automatic t_io();
        load(12'h070, '{16'h0100, 16'h7853, 16'h7a50, 16'h7c00, 16'h7a60,
            16'h7962, 16'h7c00});
        go(12'h070, 32'h0000_0001);
        chk("output word", 32'h0000_1234, {16'h0000, got_data});
        chk("output func", 32'h0000_0003, {28'h000_0000, got_func});
        chk("output count", 32'h0000_0001, {24'h00_0000, got_count});
        rd(8'h0C, 32'h0000_a5c3, "input acc");
        bus(1'b1, 8'h04, 32'h0000_0004);
        rd(8'h04, 32'h0000_0000, "status cleared");
        $display("test io done");
    endtask : t_io
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_move();
        t_skip();
        t_jump();
        t_io();
        final_report();
    end
    // The full run takes well under 3000 cycles; the limit leaves margin.
    initial begin
        repeat (30000) @(posedge clk_i);
        num_errors++;
        final_report();
    end
endmodule : accumulator_instruction_decoder_tb
`default_nettype wire
